// >>> rtl/aewc_map.vh
// constants for the area endian and width control block
`ifndef AEWC_MAP_VH
`define AEWC_MAP_VH
`define AEWC_NUM_AREAS 7
`define AEWC_AREA_W 3
`define AEWC_BOOT_W 2
`define AEWC_BOOT_MODE0 2'h0
`define AEWC_BE 1'b0
`define AEWC_LE 1'b1
`define AEWC_W16 1'b1
`define AEWC_W8 1'b0
`define AEWC_TYPE_W 2
`define AEWC_TYPE_SRAM 2'h0
`define AEWC_TYPE_SDRAM 2'h1
`define AEWC_TYPE_PCMCIA 2'h2
`define AEWC_TYPE_MPX 2'h3
`define AEWC_SIZE_W 2
`define AEWC_SIZE_BYTE 2'h0
`define AEWC_SIZE_WORD 2'h1
`define AEWC_SIZE_LONG 2'h2
`define AEWC_AREA0 3'h0
`define AEWC_MPX_WIDTH_BIT 31
`define AEWC_LANE_IDLE 16'h0000
`endif

// >>> rtl/aewc_lane.v
// byte-lane steering and strobe decode for one access
`timescale 1ns/1ps
`include "aewc_map.vh"
module aewc_lane (
  input wire little,
  input wire wide,
  input wire [1:0] size,
  input wire [1:0] addr_lo,
  input wire [31:0] wdata,
  output reg [15:0] lane_data,
  output reg we_lower,
  output reg we_upper
);
  // wide bus: byte 0 of a datum sits upper lane when big, lower lane when little
  always @* begin
    lane_data = 16'h0000;
    we_lower = 1'b0;
    we_upper = 1'b0;
    if (!wide) begin
      lane_data = {8'h00, wdata[7:0]};
      we_lower = 1'b1;
    end else if (size == `AEWC_SIZE_BYTE) begin
      lane_data = {wdata[7:0], wdata[7:0]};
      if (addr_lo[0] ^ little)
        we_lower = 1'b1;
      else
        we_upper = 1'b1;
    end else begin
      // long is sent as two halfwords by the caller; data here is one halfword
      if (little)
        lane_data = {wdata[15:8], wdata[7:0]};
      else
        lane_data = wdata[15:0];
      we_lower = 1'b1;
      we_upper = 1'b1;
    end
  end
endmodule // aewc_lane

// >>> rtl/aewc_top.v
// area endianness and bus width control
// Summary of operation
// - after power-on reset every area is big-endian
// - big-endian places the most significant byte at lowest address
// - little-endian places the least significant byte at lowest address
// - on a 16-bit bus byte 0 strobe is upper lane if big, lower lane if little; an 8-bit bus always strobes the lower lane
// - sram interface with byte select runs 8 or 16 bits per area
// - sdram always uses a fixed 16-bit bus
// - card interface width is selectable 8 or 16 bits
// - multiplexed io is fixed width or width chosen by address
// - boot mode 0 locks area 0 to 16-bit big-endian
// - boot mode 0 areas 1 to 6 default 16-bit big, reprogrammable
// - boot modes 1 to 3 all areas default 16-bit big, reprogrammable
// - boot mode 0 enables minimal read pins automatically
`timescale 1ns/1ps
`include "aewc_map.vh"
module aewc_top #(
  parameter NUM_AREAS = `AEWC_NUM_AREAS
) (
  input wire CLK_SYS,
  input wire RESETN,
  input wire CE,
  input wire [1:0] BOOT_MODE,
  input wire CFG_WE,
  input wire [2:0] CFG_AREA,
  input wire CFG_LITTLE,
  input wire CFG_WIDE,
  input wire [1:0] CFG_TYPE,
  input wire CFG_MPX_VAR,
  input wire ACC_VALID,
  input wire [2:0] ACC_AREA,
  input wire [1:0] ACC_SIZE,
  input wire [31:0] ACC_ADDR,
  input wire [31:0] ACC_WDATA,
  input wire ACC_FETCH,
  output wire ACC_BUSY,
  output reg [15:0] DATA_OUT,
  output reg WRITE_STROBE_LOWER_LANE,
  output reg WRITE_STROBE_UPPER_LANE,
  output reg ACC_ERR,
  output reg [NUM_AREAS-1:0] AREA_LITTLE,
  output reg [NUM_AREAS-1:0] AREA_WIDE,
  output reg BOOT_PINS_EN,
  output reg [1:0] BOOT_MODE_HELD
);
  // per-area settings, one bit or field per area
  reg [NUM_AREAS-1:0] little_q;
  reg [NUM_AREAS-1:0] little_d;
  reg [NUM_AREAS-1:0] wide_q;
  reg [NUM_AREAS-1:0] wide_d;
  reg [NUM_AREAS-1:0] mpxvar_q;
  reg [NUM_AREAS-1:0] mpxvar_d;
  reg [`AEWC_TYPE_W*NUM_AREAS-1:0] type_q;
  reg [`AEWC_TYPE_W*NUM_AREAS-1:0] type_d;
  reg [`AEWC_BOOT_W-1:0] mode_q;
  reg [`AEWC_BOOT_W-1:0] mode_d;
  reg mode_taken_q;
  reg mode_taken_d;
  reg busy_q;
  reg busy_d;
  reg [`AEWC_AREA_W-1:0] busy_area_q;
  reg [`AEWC_AREA_W-1:0] busy_area_d;
  reg [15:0] data_out_d;
  reg strobe_lo_d;
  reg strobe_up_d;
  reg err_d;
  reg pins_en_d;
  reg eff_wide;
  wire boot0;
  wire acc_in;
  wire cfg_take;
  wire acc_little;
  wire acc_wide;
  wire acc_mpxvar;
  wire [`AEWC_TYPE_W-1:0] acc_type;
  wire [15:0] lane_data;
  wire we_lo;
  wire we_hi;

  // area 0 is frozen only when the part came up in boot mode 0
  function locked;
    input [`AEWC_AREA_W-1:0] area;
    input b0;
    begin
      locked = b0 && (area == `AEWC_AREA0);
    end
  endfunction

  // select codes past the last area carry no settings of their own
  function area_ok;
    input [`AEWC_AREA_W-1:0] area;
    begin
      area_ok = area < NUM_AREAS;
    end
  endfunction

  assign boot0 = mode_q == `AEWC_BOOT_MODE0;
  assign acc_in = area_ok(ACC_AREA);
  // an unmapped area falls back to power-on defaults instead of going unknown
  assign acc_little = acc_in ? little_q[ACC_AREA] : `AEWC_BE;
  assign acc_wide = acc_in ? wide_q[ACC_AREA] : `AEWC_W16;
  assign acc_mpxvar = acc_in ? mpxvar_q[ACC_AREA] : 1'b0;
  assign acc_type = acc_in ? type_q[`AEWC_TYPE_W*ACC_AREA +: `AEWC_TYPE_W] : `AEWC_TYPE_SRAM;
  assign ACC_BUSY = busy_q;

  // writes to an area in use are dropped so settings never shift mid-access
  assign cfg_take = CFG_WE && mode_taken_q && area_ok(CFG_AREA) &&
    !(busy_q && busy_area_q == CFG_AREA) && !locked(CFG_AREA, boot0);

  // width per memory type
  always @* begin
    case (acc_type)
      `AEWC_TYPE_SDRAM: eff_wide = `AEWC_W16;
      `AEWC_TYPE_MPX: begin
        // a variable area takes its width from one address line per access
        if (acc_mpxvar)
          eff_wide = ACC_ADDR[`AEWC_MPX_WIDTH_BIT];
        else
          eff_wide = acc_wide;
      end
      `AEWC_TYPE_PCMCIA: eff_wide = acc_wide;
      default: eff_wide = acc_wide;
    endcase
  end

  aewc_lane u_lane (
    .little(acc_little),
    .wide(eff_wide),
    .size(ACC_SIZE),
    .addr_lo(ACC_ADDR[1:0]),
    .wdata(ACC_WDATA),
    .lane_data(lane_data),
    .we_lower(we_lo),
    .we_upper(we_hi)
  );

  // settings: strap caught once on the first enabled edge after release
  always @* begin
    mode_d = mode_q;
    mode_taken_d = mode_taken_q;
    little_d = little_q;
    wide_d = wide_q;
    mpxvar_d = mpxvar_q;
    type_d = type_q;
    if (!mode_taken_q) begin
      mode_d = BOOT_MODE;
      mode_taken_d = 1'b1;
    end
    if (cfg_take) begin
      little_d[CFG_AREA] = CFG_LITTLE;
      wide_d[CFG_AREA] = CFG_WIDE;
      mpxvar_d[CFG_AREA] = CFG_MPX_VAR;
      type_d[`AEWC_TYPE_W*CFG_AREA +: `AEWC_TYPE_W] = CFG_TYPE;
    end
  end

  // one access: data, strobes, busy and error idle low between accesses
  always @* begin
    busy_d = ACC_VALID;
    busy_area_d = ACC_AREA;
    data_out_d = `AEWC_LANE_IDLE;
    strobe_lo_d = 1'b0;
    strobe_up_d = 1'b0;
    err_d = 1'b0;
    if (ACC_VALID) begin
      data_out_d = lane_data;
      strobe_lo_d = we_lo;
      strobe_up_d = we_hi;
      // the fetch still goes out; the flag lets the master trap misplaced code
      err_d = ACC_FETCH & acc_little;
    end
    // only the read path is raised by hardware; the rest waits for software
    pins_en_d = mode_taken_q & boot0;
  end

  // single clocked process; reset is synchronous
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      // reset lands on the big-endian 16-bit sram defaults of every area
      little_q <= {NUM_AREAS{`AEWC_BE}};
      wide_q <= {NUM_AREAS{`AEWC_W16}};
      mpxvar_q <= {NUM_AREAS{1'b0}};
      type_q <= {NUM_AREAS{`AEWC_TYPE_SRAM}};
      mode_q <= `AEWC_BOOT_MODE0;
      mode_taken_q <= 1'b0;
      busy_q <= 1'b0;
      busy_area_q <= `AEWC_AREA0;
      DATA_OUT <= `AEWC_LANE_IDLE;
      WRITE_STROBE_LOWER_LANE <= 1'b0;
      WRITE_STROBE_UPPER_LANE <= 1'b0;
      ACC_ERR <= 1'b0;
      AREA_LITTLE <= {NUM_AREAS{1'b0}};
      AREA_WIDE <= {NUM_AREAS{1'b0}};
      BOOT_PINS_EN <= 1'b0;
      BOOT_MODE_HELD <= `AEWC_BOOT_MODE0;
    end else if (CE) begin
      // with the enable low every register below keeps its value
      little_q <= little_d;
      wide_q <= wide_d;
      mpxvar_q <= mpxvar_d;
      type_q <= type_d;
      mode_q <= mode_d;
      mode_taken_q <= mode_taken_d;
      busy_q <= busy_d;
      busy_area_q <= busy_area_d;
      DATA_OUT <= data_out_d;
      WRITE_STROBE_LOWER_LANE <= strobe_lo_d;
      WRITE_STROBE_UPPER_LANE <= strobe_up_d;
      ACC_ERR <= err_d;
      // mirrors trail the settings by one cycle
      AREA_LITTLE <= little_q;
      AREA_WIDE <= wide_q;
      BOOT_PINS_EN <= pins_en_d;
      BOOT_MODE_HELD <= mode_q;
    end
  end
endmodule // aewc_top

// >>> verif/aewc_sram_model.sv
// external memory stand-in that latches each strobed byte lane
`timescale 1ns/1ps
module aewc_sram_model (
  input wire clk,
  input wire we_lo,
  input wire we_up,
  input wire [15:0] data,
  output reg [15:0] mem_q
);
  always @(posedge clk) begin
    if (we_lo) mem_q[7:0] <= data[7:0];
    if (we_up) mem_q[15:8] <= data[15:8];
  end
endmodule // aewc_sram_model

// >>> verif/aewc_monitor.sv
// assertion checker for the area endian and width control
`timescale 1ns/1ps
module aewc_monitor #(parameter NUM_AREAS = 7) (
  input wire CLK_SYS,
  input wire RESETN,
  input wire ACC_VALID,
  input wire [2:0] ACC_AREA,
  input wire [1:0] ACC_SIZE,
  input wire [31:0] ACC_ADDR,
  input wire ACC_FETCH,
  input wire ACC_BUSY,
  input wire WRITE_STROBE_LOWER_LANE,
  input wire WRITE_STROBE_UPPER_LANE,
  input wire ACC_ERR,
  input wire [NUM_AREAS-1:0] AREA_LITTLE,
  input wire [NUM_AREAS-1:0] AREA_WIDE,
  input wire BOOT_PINS_EN
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  wire lo = WRITE_STROBE_LOWER_LANE;
  wire up = WRITE_STROBE_UPPER_LANE;
  wire le = AREA_LITTLE[ACC_AREA];
  wire wd = AREA_WIDE[ACC_AREA];
  wire byt = ACC_VALID && ACC_SIZE == 2'h0 && wd && !ACC_ADDR[0];
  chk_busy_echo: assert property (ACC_VALID |=> ACC_BUSY)
    else $error("busy missing");
  chk_idle_quiet: assert property (!ACC_BUSY |-> !lo && !up)
    else $error("strobe while idle");
  chk_big_byte: assert property (byt && !le |=> up && !lo)
    else $error("big byte lane");
  chk_little_byte: assert property (byt && le |=> lo && !up)
    else $error("little byte lane");
  chk_word_both: assert property (ACC_VALID && ACC_SIZE == 2'h1 && wd |=> up && lo)
    else $error("word strobes");
  chk_fetch_flag: assert property (ACC_VALID && ACC_FETCH && le |=> ACC_ERR)
    else $error("fetch not flagged");
  chk_area0_lock: assert property (BOOT_PINS_EN |-> !AREA_LITTLE[0] && AREA_WIDE[0])
    else $error("area0 unlocked");
  chk_err_cause: assert property (ACC_ERR |-> $past(ACC_FETCH))
    else $error("spurious error");
  cover property (byt && le);
  cover property (ACC_VALID && ACC_FETCH && le);
  cover property (BOOT_PINS_EN && ACC_VALID);
  cover property (ACC_BUSY && WRITE_STROBE_LOWER_LANE && !WRITE_STROBE_UPPER_LANE);
endmodule // aewc_monitor

// >>> verif/tb_top.sv
// self-checking bench for the area endian and width control
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  reg CLK_SYS = 0, RESETN = 0, CFG_WE = 0, CFG_LITTLE = 0, CFG_WIDE = 1, ACC_VALID = 0;
  reg ACC_FETCH = 0, CE = 1, CFG_MPX_VAR = 0;
  reg [1:0] BOOT_MODE = 0, CFG_TYPE = 0, ACC_SIZE = 0, m;
  reg [2:0] CFG_AREA = 0, ACC_AREA = 0;
  reg [31:0] ACC_ADDR = 0, ACC_WDATA = 0;
  reg [18:0] q[$], ex;
  wire ACC_BUSY, WRITE_STROBE_LOWER_LANE, WRITE_STROBE_UPPER_LANE, ACC_ERR, BOOT_PINS_EN;
  wire [15:0] DATA_OUT, mem;
  wire [6:0] AREA_LITTLE, AREA_WIDE;
  wire [1:0] BOOT_MODE_HELD;
  integer n_errors = 0, checks = 0, i, k;
  always #5 CLK_SYS = ~CLK_SYS;
  aewc_top uut (.CLK_SYS, .RESETN, .CE, .BOOT_MODE, .CFG_WE, .CFG_AREA, .CFG_LITTLE,
    .CFG_WIDE, .CFG_TYPE, .CFG_MPX_VAR, .ACC_VALID, .ACC_AREA, .ACC_SIZE, .ACC_ADDR,
    .ACC_WDATA, .ACC_FETCH, .ACC_BUSY, .DATA_OUT, .WRITE_STROBE_LOWER_LANE,
    .WRITE_STROBE_UPPER_LANE, .ACC_ERR, .AREA_LITTLE, .AREA_WIDE, .BOOT_PINS_EN, .BOOT_MODE_HELD);
  aewc_sram_model mdl (.clk(CLK_SYS), .we_lo(WRITE_STROBE_LOWER_LANE),
    .we_up(WRITE_STROBE_UPPER_LANE), .data(DATA_OUT), .mem_q(mem));
  task wrap_up;
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // valid is left high so calls run back to back
  task acc(input [2:0] a, input [1:0] s, input [31:0] ad, input f, input l, input w);
    reg sel;
    @(negedge CLK_SYS);
    {ACC_AREA, ACC_SIZE, ACC_ADDR, ACC_FETCH, ACC_VALID} = {a, s, ad, f, 1'h1};
    ACC_WDATA = $urandom;
    sel = s != 2'h0 || (ad[0] ^ l);
    q.push_back({f & l, w & (s != 2'h0 || !(ad[0] ^ l)), !w || sel,
      !w ? {8'h00, ACC_WDATA[7:0]} : s == 2'h0 ? {2{ACC_WDATA[7:0]}} : ACC_WDATA[15:0]});
  endtask
  // settings are only rewritten while no access runs
  task cfg(input [2:0] a, input l, input w, input [1:0] t);
    @(negedge CLK_SYS);
    {CFG_AREA, CFG_LITTLE, CFG_WIDE, CFG_TYPE, CFG_MPX_VAR, CFG_WE} =
      {a, l, w, t, t == 2'h3, 1'h1};
    @(negedge CLK_SYS) CFG_WE = 1'h0;
    repeat (2) @(negedge CLK_SYS);
  endtask
  always @(posedge CLK_SYS) begin
    #1;
    if (ACC_BUSY === 1'h1) begin
      ex = q.pop_front();
      `CHK("lanes", ex, {ACC_ERR, WRITE_STROBE_UPPER_LANE, WRITE_STROBE_LOWER_LANE, DATA_OUT})
    end
  end
  initial begin
    repeat (9000) @(posedge CLK_SYS);
    n_errors++;
    wrap_up;
  end
  initial begin
    i = $urandom(96382);
    for (i = 0; i < 2; i++) begin
      m = i ? 2'h1 + $urandom % 3 : 2'h0;
      @(negedge CLK_SYS) {RESETN, BOOT_MODE} = {1'h0, m};
      repeat (12) @(negedge CLK_SYS);
      RESETN = 1'h1;
      repeat (2) @(negedge CLK_SYS);
      // the strap moves after sampling; the held copy must not follow
      BOOT_MODE = ~m;
      repeat (2) @(negedge CLK_SYS);
      `CHK("pins", m == 2'h0, BOOT_PINS_EN)
      `CHK("held", m, BOOT_MODE_HELD)
      `CHK("little", 7'h0, AREA_LITTLE)
      `CHK("wide", 7'h7F, AREA_WIDE)
      cfg(3'h0, 1'h1, 1'h0, 2'h0);
      `CHK("area0", m != 2'h0, AREA_LITTLE[0])
      `CHK("area0w", m == 2'h0, AREA_WIDE[0])
      cfg(3'h2, 1'h1, 1'h1, 2'h0);
      cfg(3'h3, 1'h0, 1'h0, 2'h0);
      cfg(3'h4, 1'h0, 1'h0, 2'h1);
      cfg(3'h5, 1'h0, 1'h0, 2'h2);
      cfg(3'h6, 1'h0, 1'h0, 2'h3);
      for (k = 0; k < 4; k++) acc(3'h1 + k[0], 2'h0, k[1], 1'h0, k[0], 1'h1);
      acc(3'h0, 2'h0, 32'h0, 1'h0, m != 2'h0, m == 2'h0);
      acc(3'h1, 2'h1, 32'h0, 1'h0, 1'h0, 1'h1);
      acc(3'h2, 2'h1, 32'h0, 1'h1, 1'h1, 1'h1);
      acc(3'h3, 2'h0, 32'h1, 1'h0, 1'h0, 1'h0);
      acc(3'h5, 2'h0, 32'h0, 1'h0, 1'h0, 1'h0);
      acc(3'h6, 2'h1, 32'h80000000, 1'h0, 1'h0, 1'h1);
      acc(3'h6, 2'h1, 32'h0, 1'h0, 1'h0, 1'h0);
      acc(3'h4, 2'h1, 32'h0, 1'h0, 1'h0, 1'h1);
      @(negedge CLK_SYS) ACC_VALID = 1'h0;
      repeat (3) @(negedge CLK_SYS);
      `CHK("drain", 32'h0, q.size())
      `CHK("mem", ACC_WDATA[15:0], mem)
      // a write offered while the enable is low must never land
      CE = 1'h0;
      cfg(3'h1, 1'h1, 1'h1, 2'h0);
      `CHK("freeze", 1'h0, AREA_LITTLE[1])
      CE = 1'h1;
    end
    wrap_up;
  end
endmodule // tb_top
bind aewc_top aewc_monitor #(.NUM_AREAS(NUM_AREAS)) chk (.CLK_SYS, .RESETN, .ACC_VALID,
  .ACC_AREA, .ACC_SIZE, .ACC_ADDR, .ACC_FETCH, .ACC_BUSY, .WRITE_STROBE_LOWER_LANE,
  .WRITE_STROBE_UPPER_LANE, .ACC_ERR, .AREA_LITTLE, .AREA_WIDE, .BOOT_PINS_EN);
